/* File: rtl/qp_pkg.sv */
package qp_pkg;

  // ==========================================================
  // identity and opcodes
  localparam logic [3:0] QP_TYPE_CODE     = 4'h6; // arbitrary value, not a real part code
  localparam logic [3:0] QP_OP_RD_WIPER   = 4'h9;
  localparam logic [3:0] QP_OP_WR_WIPER   = 4'ha;
  localparam logic [3:0] QP_OP_RD_SETTING = 4'hb;
  localparam logic [3:0] QP_OP_WR_SETTING = 4'hc;

  // ==========================================================
  // widths and reset values
  localparam int          QP_POTS       = 4;
  localparam int          QP_SETTINGS   = 4;
  localparam logic [3:0]  QP_BYTE_BITS  = 4'h8;
  localparam logic [3:0]  QP_LAST_BIT   = 4'h7;
  localparam logic [5:0]  QP_NV_RESET   = 6'h00;
  localparam logic [19:0] QP_CNT_ZERO   = 20'h00000;

  // ==========================================================
  // timing
  localparam int QP_CLK_HZ                 = 100_000_000;
  localparam int QP_NV_PROGRAM_TIME_US     = 5000;
  localparam int QP_POWERUP_WRITE_DELAY_US = 1000;
  // longest time: rounds down
  localparam int QP_NV_PROGRAM_CYCLES      = QP_NV_PROGRAM_TIME_US * (QP_CLK_HZ / 1_000_000);

  // ==========================================================
  // types
  typedef enum logic [2:0] {QP_IDLE, QP_RX, QP_ACK, QP_TX, QP_MACK, QP_WAIT} qp_state_t;
  typedef enum logic [1:0] {QP_PH_ADDR, QP_PH_INSTR, QP_PH_DATA} qp_phase_t;

  typedef struct packed {
    logic [3:0] opcode;
    logic       setting_sel_hi;
    logic       setting_sel_lo;
    logic [1:0] pot_sel;
  } qp_instr_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic rise;
    logic fall;
  } qp_bus_ev_t;

endpackage : qp_pkg

/* File: rtl/qp_slave.sv */
`timescale 1ns/1ps
// Operation
// R1: detect start as data falling with clock high; ignore bus until then
// R2: master ends every operation with a stop (data rising, clock high)
// R3: data changes while clock high are start or stop events
// R4: master starts only on idle bus and makes all clocks
// R5: address byte is type code nibble then four strap-pin bits
// R6: acknowledge address only when type code and straps both match
// R7: receiver acknowledges each byte by pulling data low on ninth clock
// R8: acknowledge every received write byte, except protected data-register data
// R9: read mode shifts out 8 bits, releases, samples master acknowledge
// R10: no master acknowledge ends transmission; release and wait for stop
// R11: write is address, instruction, data, each acknowledged, then stop
// R12: instruction is opcode nibble, two setting-select bits, two pot-select bits
// R13: stop ending a setting-register write starts non-volatile programming
// R14: during programming interface disabled, data released, address ignored
// R15: polling address gets no acknowledge while busy, acknowledge when done
// R16: write protect low refuses data byte of setting write, no programming
// R17: protect before programming blocks it; after programming starts no effect
// R18: master waits 1 ms after power-up before any operation
// R19: each pot has 6-bit wiper and four 6-bit non-volatile settings
// R20: setting-select pair picks setting zero through three
// R21: unmatched address ignores rest of transaction until next start
module qp_slave
  import qp_pkg::*;
#(
  parameter int NV_PROGRAM_CYCLES = QP_NV_PROGRAM_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        strap_addr_bit0,
  input  wire logic        strap_addr_bit1,
  input  wire logic        strap_addr_bit2,
  input  wire logic        strap_addr_bit3,
  input  wire logic        write_protect_n,
  output logic [23:0]      wiper_position,
  output logic             nv_busy
);

  // ==========================================================
  // pin synchronisers and bus events
  logic       scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic       sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic [4:0] pin_meta_reg, pin_sync_reg;
  qp_bus_ev_t ev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
      pin_meta_reg <= 5'h10;
      pin_sync_reg <= 5'h10;
    end else begin
      scl_meta_reg <= scl_in;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= sda_in;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
      pin_meta_reg <= {write_protect_n, strap_addr_bit3, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // data edge during clock high is framing, never data
  assign ev.start = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg; // [R1] [R3]
  assign ev.stop  = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg; // [R3]
  assign ev.rise  = scl_sync_reg & ~scl_prev_reg;
  assign ev.fall  = ~scl_sync_reg & scl_prev_reg;

  // ==========================================================
  // state
  qp_state_t   state_reg, state_next;
  qp_phase_t   phase_reg, phase_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic [7:0]  shift_reg, shift_next;
  qp_instr_t   instr_reg, instr_next;
  logic [5:0]  wr_data_reg, wr_data_next;
  logic        wr_pend_reg, wr_pend_next;
  logic        tx_ack_reg, tx_ack_next;
  logic        sda_oe_reg;
  logic [19:0] nv_cnt_reg;
  logic [5:0]  wiper_reg [QP_POTS];
  logic [5:0]  nv_reg [QP_POTS*QP_SETTINGS];

  // ==========================================================
  // decode
  wire [3:0] strap_addr    = pin_sync_reg[3:0];
  wire       wp_ok         = pin_sync_reg[4]; // [R17]
  wire       busy          = nv_cnt_reg != QP_CNT_ZERO;
  wire       byte_done     = ev.fall && bit_cnt_reg == QP_BYTE_BITS;
  wire       addr_match    = shift_reg[7:4] == QP_TYPE_CODE && shift_reg[3:0] == strap_addr && !busy; // [R5] [R6] [R14]
  wire       is_wr_wiper   = instr_reg.opcode == QP_OP_WR_WIPER;
  wire       is_wr_setting = instr_reg.opcode == QP_OP_WR_SETTING;
  // protected setting data gets no acknowledge
  wire       data_ok       = is_wr_wiper || (is_wr_setting && wp_ok && !busy); // [R8] [R16]
  qp_instr_t instr_rx;
  assign instr_rx = qp_instr_t'(shift_reg); // [R12]
  wire       rd_op         = instr_reg.opcode == QP_OP_RD_WIPER || instr_reg.opcode == QP_OP_RD_SETTING;
  wire [3:0] sel_idx       = {instr_reg.pot_sel, instr_reg.setting_sel_hi, instr_reg.setting_sel_lo}; // [R20]
  // held instruction, not the shifter: it is emptied by the time a repeat byte loads
  wire [5:0] rd_value      = (instr_reg.opcode == QP_OP_RD_WIPER) ? wiper_reg[instr_reg.pot_sel] : nv_reg[sel_idx];
  wire       commit        = ev.stop && wr_pend_reg; // [R11]
  wire       wiper_wr      = commit && is_wr_wiper;
  // protect is checked again at the stop so a late low still blocks
  wire       nv_start      = commit && is_wr_setting && wp_ok; // [R13] [R17]

  // ==========================================================
  // protocol state machine
  always_comb begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    shift_next   = shift_reg;
    instr_next   = instr_reg;
    wr_data_next = wr_data_reg;
    wr_pend_next = wr_pend_reg;
    tx_ack_next  = tx_ack_reg;
    if (ev.start) begin // [R1]
      state_next   = QP_RX;
      phase_next   = QP_PH_ADDR;
      bit_cnt_next = 4'h0;
      wr_pend_next = 1'b0;
    end else if (ev.stop) begin // [R11]
      state_next   = QP_IDLE;
      wr_pend_next = 1'b0;
    end else begin
      case (state_reg)
        QP_RX: begin
          if (ev.rise) begin
            shift_next   = {shift_reg[6:0], sda_sync_reg};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_next = QP_WAIT; // [R21] [R16]
            if (phase_reg == QP_PH_ADDR && addr_match) begin
              state_next = QP_ACK; // [R6] [R15]
            end else if (phase_reg == QP_PH_INSTR) begin
              state_next = QP_ACK; // [R8]
              instr_next = instr_rx;
            end else if (phase_reg == QP_PH_DATA && data_ok) begin
              state_next   = QP_ACK;
              wr_data_next = shift_reg[5:0]; // [R19]
            end
          end
        end
        QP_ACK: begin
          if (ev.fall) begin // [R7]
            bit_cnt_next = 4'h0;
            state_next   = QP_RX;
            if (phase_reg == QP_PH_ADDR) begin
              phase_next = QP_PH_INSTR;
            end else if (phase_reg == QP_PH_INSTR) begin
              phase_next = QP_PH_DATA;
              if (rd_op) begin
                state_next = QP_TX; // [R9]
                shift_next = {2'b00, rd_value};
              end
            end else begin
              // extra bytes past the data byte are ignored
              state_next   = QP_WAIT;
              wr_pend_next = 1'b1;
            end
          end
        end
        QP_TX: begin
          if (ev.fall) begin // [R9]
            shift_next   = {shift_reg[6:0], 1'b0};
            bit_cnt_next = bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == QP_LAST_BIT) begin
              state_next   = QP_MACK;
              bit_cnt_next = 4'h0;
            end
          end
        end
        QP_MACK: begin
          if (ev.rise) begin
            tx_ack_next = ~sda_sync_reg; // [R9]
          end else if (ev.fall) begin
            state_next = QP_WAIT; // [R10]
            if (tx_ack_reg) begin
              state_next = QP_TX;
              shift_next = {2'b00, rd_value};
            end
          end
        end
        default: begin
        end
      endcase
    end
  end

  // open drain: only ever pull low
  wire sda_oe_next = state_next == QP_ACK || (state_next == QP_TX && !shift_next[7]); // [R7] [R10] [R14]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg   <= QP_IDLE;
      phase_reg   <= QP_PH_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg   <= 8'h00;
      instr_reg   <= '0;
      wr_data_reg <= 6'h00;
      wr_pend_reg <= 1'b0;
      tx_ack_reg  <= 1'b0;
      sda_oe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      shift_reg   <= shift_next;
      instr_reg   <= instr_next;
      wr_data_reg <= wr_data_next;
      wr_pend_reg <= wr_pend_next;
      tx_ack_reg  <= tx_ack_next;
      sda_oe_reg  <= sda_oe_next;
    end
  end

  // ==========================================================
  // programming timer and register storage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      nv_cnt_reg <= QP_CNT_ZERO;
    end else if (nv_start) begin
      nv_cnt_reg <= 20'(NV_PROGRAM_CYCLES); // [R13] [R14]
    end else if (busy) begin
      nv_cnt_reg <= nv_cnt_reg - 20'h00001;
    end
  end

  // no power loss here, so reset stands in for the power-up recall
  for (genvar i = 0; i < QP_POTS * QP_SETTINGS; i++) begin : g_nv
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        nv_reg[i] <= QP_NV_RESET;
      end else if (nv_start && sel_idx == 4'(i)) begin
        nv_reg[i] <= wr_data_reg; // [R19] [R20]
      end
    end
  end

  for (genvar p = 0; p < QP_POTS; p++) begin : g_wiper
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        wiper_reg[p] <= QP_NV_RESET;
      end else if (wiper_wr && instr_reg.pot_sel == 2'(p)) begin
        wiper_reg[p] <= wr_data_reg; // [R19]
      end
    end
    assign wiper_position[p*6 +: 6] = wiper_reg[p];
  end

  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;
  assign nv_busy = busy;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_start_resync: assert property (ev.start |=> state_reg == QP_RX && bit_cnt_reg == 4'h0) // [R1]
    else $error("start did not restart address reception");
  chk_stop_idle: assert property (ev.stop && !ev.start |=> state_reg == QP_IDLE ##1 !sda_oe_reg) // [R11]
    else $error("stop did not return to idle");
  chk_addr_mismatch: assert property (state_reg == QP_RX && phase_reg == QP_PH_ADDR && byte_done && !addr_match
    |=> state_reg == QP_WAIT ##1 !sda_oe_reg) // [R6]
    else $error("unmatched address acknowledged");
  chk_busy_no_ack: assert property (busy && state_reg == QP_RX && phase_reg == QP_PH_ADDR && byte_done
    |=> state_reg != QP_ACK) // [R14]
    else $error("address acknowledged while programming");
  chk_wp_refuse: assert property (state_reg == QP_RX && phase_reg == QP_PH_DATA && byte_done && is_wr_setting
    && !wp_ok |=> state_reg == QP_WAIT && !wr_pend_reg) // [R16]
    else $error("protected data byte acknowledged");
  chk_nv_timer: assert property (nv_start |=> nv_cnt_reg == 20'(NV_PROGRAM_CYCLES) ##1
    nv_cnt_reg == 20'(NV_PROGRAM_CYCLES - 1)) // [R13]
    else $error("programming timer not loaded");
  chk_ack_drive: assert property (state_reg == QP_ACK && $past(state_reg) == QP_ACK |-> sda_oe_reg) // [R7]
    else $error("acknowledge not driven");
  chk_nack_release: assert property (state_reg == QP_MACK && ev.fall && !tx_ack_reg && !ev.start && !ev.stop
    |=> state_reg == QP_WAIT ##1 !sda_oe_reg) // [R10]
    else $error("transmit continued after no acknowledge");
  chk_wp_late: assert property (busy && !wp_ok |=> nv_cnt_reg == $past(nv_cnt_reg) - 20'h00001) // [R17]
    else $error("protect disturbed running programming");

  cov_addr_ack: cover property (state_reg == QP_RX && phase_reg == QP_PH_ADDR ##1 state_reg == QP_ACK);
  cov_nv_program: cover property (nv_start);
  cov_read_byte: cover property (state_reg == QP_TX ##1 state_reg == QP_MACK);
  cov_poll_busy: cover property (busy && ev.start);

endmodule : qp_slave

/* File: dv/qp_master.sv */
`timescale 1ns/1ps
// ==========================================================
// bus master model: makes every clock, holds data while clock high
module qp_master (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // idle bus: clock high and stands still between frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wait_q();
    repeat (3) @(posedge clk);
  endtask : wait_q

  // clock low without a start, used to probe an unstarted bus
  task automatic park();
    scl <= 1'b0;
    wait_q();
  endtask : park

  // data released first so a repeated start also works
  task automatic start_ev();
    sda_low <= 1'b0;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_low <= 1'b1;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask : start_ev

  // every operation closes with a stop
  task automatic stop_ev();
    sda_low <= 1'b1;
    wait_q();
    scl <= 1'b1;
    wait_q();
    sda_low <= 1'b0;
    wait_q();
  endtask : stop_ev

  // data moves only with clock low
  task automatic bit_x(input logic b, output logic r);
    sda_low <= !b;
    wait_q();
    scl <= 1'b1;
    wait_q();
    r = sda;
    wait_q();
    scl <= 1'b0;
    wait_q();
  endtask : bit_x

  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask : put_byte

  // master acknowledge low on the ninth pulse when more is wanted
  task automatic get_byte(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, d[i]);
    end
    bit_x(!mack, r);
  endtask : get_byte
endmodule : qp_master

/* File: dv/quad_pot_i2c_slave_write_ctrl_tb.sv */
`timescale 1ns/1ps
module quad_pot_i2c_slave_write_ctrl_tb
  import qp_pkg::*;
;
  localparam int NV_CYC = 200;
  logic        clk;
  logic        rst_n;
  logic        wp_n;
  logic [3:0]  straps;
  logic        sda_out;
  logic        sda_oe;
  logic [23:0] wiper_position;
  logic        nv_busy;
  logic        scl;
  logic        mst_low;
  logic [31:0] seed = 32'h00014cbe;
  logic [31:0] tmp;
  logic [5:0]  wip [4];
  logic [5:0]  sett [4][4];
  int          errors = 0;
  int          total_checks = 0;
  int          cycles = 0;
  // pulled-up line: low when either party pulls
  wire         sda = !(sda_oe | mst_low);

  qp_slave #(.NV_PROGRAM_CYCLES(NV_CYC)) i_dut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .strap_addr_bit0(straps[0]), .strap_addr_bit1(straps[1]), .strap_addr_bit2(straps[2]),
    .strap_addr_bit3(straps[3]), .write_protect_n(wp_n), .wiper_position(wiper_position), .nv_busy(nv_busy));
  qp_master i_mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(mst_low));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // three-byte write; acks packed as address, instruction, data
  task automatic wr3(input logic [3:0] op, input logic [3:0] sel, input logic [7:0] d, output logic [2:0] a);
    i_mst.start_ev();
    i_mst.put_byte({QP_TYPE_CODE, straps}, a[2]);
    i_mst.put_byte({op, sel}, a[1]);
    i_mst.put_byte(d, a[0]);
    i_mst.stop_ev();
  endtask : wr3

  // two bytes: first acknowledged by master, second left without
  task automatic rd2(input logic [3:0] op, input logic [3:0] sel, output logic [7:0] d1, output logic [7:0] d2);
    logic a;
    i_mst.start_ev();
    i_mst.put_byte({QP_TYPE_CODE, straps}, a);
    i_mst.put_byte({op, sel}, a);
    i_mst.get_byte(1'b1, d1);
    i_mst.get_byte(1'b0, d2);
    repeat (8) @(posedge clk);
    chk("released_after_nack", 24'h0, {23'h0, sda_oe});
    i_mst.stop_ev();
  endtask : rd2

  task automatic poll(output logic a);
    i_mst.start_ev();
    i_mst.put_byte({QP_TYPE_CODE, straps}, a);
    i_mst.stop_ev();
  endtask : poll

  always @(posedge clk) begin
    cycles++;
    if (cycles == 80000) begin
      errors++;
      wrap_up();
    end
  end

  initial begin
    logic [2:0] a3;
    logic       a;
    logic [7:0] d1;
    logic [7:0] d2;
    logic [1:0] p;
    rst_n = 1'b0;
    wp_n = 1'b1;
    straps = 4'h0;
    foreach (wip[i]) wip[i] = QP_NV_RESET;
    foreach (sett[i, j]) sett[i][j] = QP_NV_RESET;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tmp = rnd();
    straps <= tmp[3:0];
    // short stand-in for the power-up wait before any operation
    repeat (20) @(posedge clk);
    chk("reset_wiper", 24'h0, wiper_position);
    chk("reset_busy", 24'h0, {23'h0, nv_busy});
    chk("open_drain_low", 24'h0, {23'h0, sda_out});
    i_mst.park();
    i_mst.put_byte({QP_TYPE_CODE, straps}, a);
    chk("ack_without_start", 24'h0, {23'h0, a});
    i_mst.stop_ev();
    for (int k = 0; k < 4; k++) begin
      i_mst.start_ev();
      i_mst.put_byte(k[0] ? {QP_TYPE_CODE, straps ^ (4'h1 << k)} : {QP_TYPE_CODE ^ (4'h1 << k), straps}, a);
      chk("ack_wrong_addr", 24'h0, {23'h0, a});
      i_mst.put_byte({QP_TYPE_CODE, straps}, a);
      chk("ack_after_mismatch", 24'h0, {23'h0, a});
      i_mst.stop_ev();
    end
    for (int k = 0; k < 4; k++) begin
      tmp = rnd();
      wr3(QP_OP_WR_WIPER, k[3:0], tmp[7:0], a3);
      chk("wiper_write_acks", 24'h7, {21'h0, a3});
      wip[k] = tmp[5:0];
      repeat (2) @(posedge clk);
      chk("wiper_position", {wip[3], wip[2], wip[1], wip[0]}, wiper_position);
    end
    for (int k = 0; k < 4; k++) begin
      rd2(QP_OP_RD_WIPER, k[3:0], d1, d2);
      chk("read_wiper", {16'h0, 2'b00, wip[k]}, {16'h0, d1});
      chk("read_wiper_again", {16'h0, 2'b00, wip[k]}, {16'h0, d2});
    end
    for (int s = 0; s < 4; s++) begin
      tmp = rnd();
      p = tmp[9:8];
      wr3(QP_OP_WR_SETTING, {s[1:0], p}, tmp[7:0], a3);
      chk("setting_write_acks", 24'h7, {21'h0, a3});
      sett[p][s] = tmp[5:0];
      repeat (2) @(posedge clk);
      chk("busy_after_stop", 24'h1, {23'h0, nv_busy});
      // protect raised mid-programming leaves the write standing
      if (s == 3) wp_n <= 1'b0;
      poll(a);
      chk("poll_while_busy", 24'h0, {23'h0, a});
      for (int n = 0; n < 400 && nv_busy !== 1'b0; n++) @(posedge clk);
      chk("busy_ends", 24'h0, {23'h0, nv_busy});
      wp_n <= 1'b1;
      poll(a);
      chk("poll_when_done", 24'h1, {23'h0, a});
      rd2(QP_OP_RD_SETTING, {s[1:0], p}, d1, d2);
      chk("read_setting", {16'h0, 2'b00, sett[p][s]}, {16'h0, d1});
      chk("read_setting_again", {16'h0, 2'b00, sett[p][s]}, {16'h0, d2});
    end
    wp_n <= 1'b0;
    tmp = rnd();
    p = tmp[9:8];
    wr3(QP_OP_WR_SETTING, {2'b10, p}, ~{2'b00, sett[p][2]}, a3);
    chk("protected_acks", 24'h6, {21'h0, a3});
    repeat (2) @(posedge clk);
    chk("protected_no_busy", 24'h0, {23'h0, nv_busy});
    wp_n <= 1'b1;
    rd2(QP_OP_RD_SETTING, {2'b10, p}, d1, d2);
    chk("protected_unchanged", {16'h0, 2'b00, sett[p][2]}, {16'h0, d1});
    wrap_up();
  end
endmodule : quad_pot_i2c_slave_write_ctrl_tb
